//--- logic/plk_ctrl_end.sv
`timescale 1ns/1ps
module plk_ctrl_end #(
  parameter int SCAN_CYCLES = plk_pkg::TRIG_SCAN_CYCLES,
  parameter int CYCLIC_CYCLES = plk_pkg::CYCLIC_CYCLES
)(
  input wire logic clock,
  input wire logic reset,
  plk_link_if.ctrl_end link,
  input wire logic set_triggered,
  input wire logic set_trig_init,
  input wire plk_pkg::plk_proto_type set_proto,
  input wire logic [7:0] set_plc_id,
  input wire logic [7:0] set_station,
  input wire logic [1:0] set_unit_sel,
  input wire logic [2:0] set_sheets,
  input wire logic cfg_lock,
  input wire logic line_we,
  input wire logic [plk_pkg::LINE_W-1:0] line_idx,
  input wire logic [plk_pkg::ADDR_W-1:0] line_ctrl_addr,
  input wire logic [plk_pkg::ADDR_W-1:0] line_plc_addr,
  input wire logic line_ram,
  input wire logic sheet_we,
  input wire logic [plk_pkg::SHEET_W-1:0] sheet_idx,
  input wire logic [plk_pkg::LINE_W-1:0] sheet_first,
  input wire logic [plk_pkg::CNT_W-1:0] sheet_count,
  input wire logic [plk_pkg::ADDR_W-1:0] sheet_trig_addr,
  input wire logic [plk_pkg::ADDR_W-1:0] sheet_notify_addr,
  input wire logic mon_we,
  input wire logic [plk_pkg::ADDR_W-1:0] mon_addr,
  input wire logic [plk_pkg::DATA_W-1:0] mon_data,
  output logic link_active,
  output logic host_comm_enable,
  output logic cfg_error,
  output logic link_error,
  output logic write_refused,
  output logic ctrl_wr_valid,
  output logic [plk_pkg::ADDR_W-1:0] ctrl_wr_addr,
  output logic [plk_pkg::DATA_W-1:0] ctrl_wr_data,
  output logic ctrl_wr_ram
);
  import plk_pkg::*;
  localparam logic [TIMER_W-1:0] SCAN_LOAD = TIMER_W'(SCAN_CYCLES - 1);
  localparam logic [TIMER_W-1:0] CYCLIC_LOAD = TIMER_W'(CYCLIC_CYCLES - 1);

  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_WAIT = 8'h02,
    ST_TRIG_RD = 8'h04,
    ST_TRIG_CLR = 8'h08,
    ST_FILL = 8'h10,
    ST_DRAIN = 8'h20,
    ST_NOTIFY = 8'h40,
    ST_HALT = 8'h80
  } plk_ctrl_st_type;

  typedef struct packed {
    plk_ctrl_st_type state;
    logic triggered;
    logic trig_init;
    plk_proto_type proto;
    logic [7:0] plc_id;
    logic [2:0] sheets;
    logic [TIMER_W-1:0] timer;
    logic [SHEET_W-1:0] sheet;
    logic [CNT_W-1:0] fill_line;
    logic [CNT_W-1:0] drain_line;
    logic [SHEETS-1:0] prev_on;
    logic pending;
    logic sent;
    logic req_write;
    logic [ADDR_W-1:0] req_addr;
    logic [DATA_W-1:0] req_data;
    logic active;
    logic host_en;
    logic cfg_error;
    logic link_error;
    logic refused;
    logic wr_valid;
    logic [ADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0] wr_data;
    logic wr_ram;
  } plk_ctrl_state_type;

  plk_ctrl_state_type state_reg, state_next;
  logic [ADDR_W-1:0] line_ctrl_mem [LINES];
  logic [ADDR_W-1:0] line_plc_mem [LINES];
  logic line_ram_mem [LINES];
  logic [LINE_W-1:0] sheet_first_mem [SHEETS];
  logic [CNT_W-1:0] sheet_count_mem [SHEETS];
  logic [ADDR_W-1:0] sheet_trig_mem [SHEETS];
  logic [ADDR_W-1:0] sheet_notify_mem [SHEETS];
  logic [DATA_W-1:0] ctrl_mem [CTRL_WORDS];

  logic fifo_in_valid;
  logic fifo_in_ready;
  logic [DATA_W-1:0] fifo_in_data;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [DATA_W-1:0] fifo_out_data;
  logic rsp;
  logic [LINE_W-1:0] line_f;
  logic [LINE_W-1:0] line_d;
  logic [CNT_W-1:0] count_now;
  plk_hit_type hit_f;
  plk_hit_type hit_d;
  plk_hit_type hit_m;
  plk_hit_type hit_w;

  plk_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock(clock),
    .reset(reset),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  function automatic plk_ctrl_state_type issue(input plk_ctrl_state_type s,
      input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    issue = s;
    issue.pending = 1'b1;
    issue.sent = 1'b1;
    issue.req_write = wr;
    issue.req_addr = a;
    issue.req_data = d;
  endfunction

  function automatic plk_ctrl_state_type next_sheet(input plk_ctrl_state_type s);
    next_sheet = s;
    next_sheet.fill_line = '0;
    next_sheet.drain_line = '0;
    if (3'(s.sheet) + 3'h1 >= s.sheets) begin
      next_sheet.sheet = '0;
      next_sheet.state = ST_WAIT;
      next_sheet.timer = s.triggered ? SCAN_LOAD : CYCLIC_LOAD;
    end else begin
      next_sheet.sheet = s.sheet + 1'b1;
      next_sheet.state = s.triggered ? ST_TRIG_RD : ST_FILL;
    end
  endfunction

  assign rsp = link.rsp_valid && state_reg.pending;
  assign line_f = sheet_first_mem[state_reg.sheet] + state_reg.fill_line[LINE_W-1:0];
  assign line_d = sheet_first_mem[state_reg.sheet] + state_reg.drain_line[LINE_W-1:0];
  assign count_now = sheet_count_mem[state_reg.sheet];
  assign hit_f = plk_reg_lookup(line_ctrl_mem[line_f]);
  assign hit_d = plk_reg_lookup(line_ctrl_mem[line_d]);
  assign hit_m = plk_reg_lookup(mon_addr);
  assign hit_w = plk_reg_lookup(state_reg.wr_addr);

  always_comb begin
    state_next = state_reg;
    state_next.wr_valid = 1'b0;
    fifo_in_valid = 1'b0;
    fifo_in_data = '0;
    fifo_out_ready = 1'b0;
    if (rsp) begin
      state_next.pending = 1'b0;
      if (link.rsp_error) state_next.link_error = 1'b1;
    end
    case (state_reg.state)
      ST_IDLE: if (cfg_lock) begin
        // Captured once; later changes wait for the next power cycle
        state_next.triggered = set_triggered;
        state_next.trig_init = set_trig_init;
        state_next.proto = set_proto;
        state_next.plc_id = set_plc_id;
        state_next.sheets = set_sheets;
        state_next.timer = '0;
        if (set_station >= STATION_MIN && set_station <= plk_max_units(set_unit_sel) &&
            set_plc_id != set_station && set_plc_id != ID_RESERVED_HI &&
            set_plc_id != ID_RESERVED_LO && set_sheets != '0 && set_sheets <= 3'(SHEETS)) begin
          state_next.state = ST_WAIT;
          state_next.active = 1'b1;
          state_next.host_en = 1'b0;
        end else begin
          state_next.state = ST_HALT;
          state_next.cfg_error = 1'b1;
        end
      end
      ST_WAIT: begin
        if (state_reg.timer == '0) begin
          state_next.sheet = '0;
          state_next.fill_line = '0;
          state_next.drain_line = '0;
          state_next.state = state_reg.triggered ? ST_TRIG_RD : ST_FILL;
        end else begin
          state_next.timer = state_reg.timer - 1'b1;
        end
      end
      ST_TRIG_RD: begin
        if (!state_reg.sent) begin
          state_next = issue(state_next, 1'b0, sheet_trig_mem[state_reg.sheet], '0);
        end else if (rsp) begin
          state_next.sent = 1'b0;
          // Only an OFF to ON change starts a transfer; short pulses may be missed
          if (link.rsp_data != '0 && !state_reg.prev_on[state_reg.sheet]) begin
            // A self-cleared trigger is remembered as OFF
            state_next.prev_on[state_reg.sheet] = !state_reg.trig_init;
            state_next.state = state_reg.trig_init ? ST_TRIG_CLR : ST_FILL;
          end else begin
            state_next.prev_on[state_reg.sheet] = link.rsp_data != '0;
            state_next = next_sheet(state_next);
          end
        end
      end
      ST_TRIG_CLR: begin
        if (!state_reg.sent) begin
          state_next = issue(state_next, 1'b1, sheet_trig_mem[state_reg.sheet], '0);
        end else if (rsp) begin
          state_next.sent = 1'b0;
          state_next.state = ST_FILL;
        end
      end
      ST_FILL: begin
        if (state_reg.sent) begin
          if (rsp) begin
            // Room was checked before the read went out
            fifo_in_valid = 1'b1;
            fifo_in_data = link.rsp_data;
            state_next.fill_line = state_reg.fill_line + 1'b1;
            state_next.sent = 1'b0;
          end
        end else if (state_reg.fill_line == count_now || !fifo_in_ready) begin
          state_next.state = ST_DRAIN;
        end else if (state_reg.triggered) begin
          state_next = issue(state_next, 1'b0, line_plc_mem[line_f], '0);
        end else begin
          // Both read-only and read/write items may go to the PLC
          fifo_in_valid = 1'b1;
          fifo_in_data = hit_f.hit ? ctrl_mem[hit_f.idx] : '0;
          state_next.fill_line = state_reg.fill_line + 1'b1;
        end
      end
      ST_DRAIN: begin
        if (!fifo_out_valid) begin
          state_next.state = state_reg.fill_line == count_now ? ST_NOTIFY : ST_FILL;
        end else if (state_reg.triggered) begin
          fifo_out_ready = 1'b1;
          state_next.drain_line = state_reg.drain_line + 1'b1;
          if (hit_d.hit && hit_d.writable) begin
            state_next.wr_valid = 1'b1;
            state_next.wr_addr = line_ctrl_mem[line_d];
            state_next.wr_data = fifo_out_data;
            state_next.wr_ram = line_ram_mem[line_d];
          end else begin
            state_next.refused = 1'b1;
          end
        end else if (!state_reg.sent) begin
          state_next = issue(state_next, 1'b1, line_plc_mem[line_d], fifo_out_data);
        end else if (rsp) begin
          fifo_out_ready = 1'b1;
          state_next.drain_line = state_reg.drain_line + 1'b1;
          state_next.sent = 1'b0;
        end
      end
      ST_NOTIFY: begin
        if (!state_reg.sent) begin
          state_next = issue(state_next, 1'b1, sheet_notify_mem[state_reg.sheet],
                             DATA_W'(count_now));
        end else if (rsp) begin
          state_next.sent = 1'b0;
          state_next = next_sheet(state_next);
        end
      end
      ST_HALT: state_next.state = ST_HALT;
      default: state_next.state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state_reg <= '0;
      state_reg.state <= ST_IDLE;
      state_reg.host_en <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // Tables may be loaded only until settings are captured
  always_ff @(posedge clock) begin
    if (line_we && state_reg.state == ST_IDLE) begin
      line_ctrl_mem[line_idx] <= line_ctrl_addr;
      line_plc_mem[line_idx] <= line_plc_addr;
      line_ram_mem[line_idx] <= line_ram;
    end
    if (sheet_we && state_reg.state == ST_IDLE) begin
      sheet_first_mem[sheet_idx] <= sheet_first;
      sheet_count_mem[sheet_idx] <= sheet_count;
      sheet_trig_mem[sheet_idx] <= sheet_trig_addr;
      sheet_notify_mem[sheet_idx] <= sheet_notify_addr;
    end
  end

  // A link write wins over a monitor update of the same cycle
  always_ff @(posedge clock) begin
    if (state_reg.wr_valid) ctrl_mem[hit_w.idx] <= state_reg.wr_data;
    else if (mon_we && hit_m.hit) ctrl_mem[hit_m.idx] <= mon_data;
  end

  assign link.req_valid = state_reg.pending;
  assign link.req_write = state_reg.req_write;
  assign link.req_proto = state_reg.proto;
  assign link.req_id = state_reg.plc_id;
  assign link.req_addr = state_reg.req_addr;
  assign link.req_data = state_reg.req_data;
  assign link_active = state_reg.active;
  assign host_comm_enable = state_reg.host_en;
  assign cfg_error = state_reg.cfg_error;
  assign link_error = state_reg.link_error;
  assign write_refused = state_reg.refused;
  assign ctrl_wr_valid = state_reg.wr_valid;
  assign ctrl_wr_addr = state_reg.wr_addr;
  assign ctrl_wr_data = state_reg.wr_data;
  assign ctrl_wr_ram = state_reg.wr_ram;
endmodule // plk_ctrl_end

//--- shared/plk_pkg.sv
package plk_pkg;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 16;
  localparam int LINES = 64;
  localparam int LINE_W = 6;
  localparam int CNT_W = 7;
  localparam int SHEETS = 4;
  localparam int SHEET_W = 2;
  localparam int FIFO_DEPTH = 16;
  localparam int PLC_MEM_WORDS = 256;
  localparam int TIMER_W = 24;
  localparam logic [7:0] ID_RESERVED_HI = 8'hff;
  localparam logic [7:0] ID_RESERVED_LO = 8'hfe;
  localparam logic [7:0] STATION_MIN = 8'h01;
  localparam logic [7:0] UNITS_8 = 8'h08;
  localparam logic [7:0] UNITS_16 = 8'h10;
  localparam logic [7:0] UNITS_24 = 8'h18;
  localparam logic [7:0] UNITS_31 = 8'h1f;
  localparam int CLOCK_HZ = 25_000_000;
  localparam int TRIG_SCAN_US = 1000;
  localparam int CYCLIC_US = 10000;
  localparam int TRIG_SCAN_CYCLES = TRIG_SCAN_US * (CLOCK_HZ / 1_000_000);
  localparam int CYCLIC_CYCLES = CYCLIC_US * (CLOCK_HZ / 1_000_000);

  typedef enum logic [1:0] {
    PROTO_FRAME3C = 2'h0,
    PROTO_NODE = 2'h1,
    PROTO_RTU = 2'h2
  } plk_proto_type;

  typedef struct packed {
    logic hit;
    logic writable;
    logic [4:0] idx;
  } plk_hit_type;

  localparam int CTRL_WORDS = 27;

  function automatic logic [7:0] plk_max_units(input logic [1:0] sel);
    case (sel)
      2'h1: plk_max_units = UNITS_16;
      2'h2: plk_max_units = UNITS_24;
      2'h3: plk_max_units = UNITS_31;
      default: plk_max_units = UNITS_8;
    endcase
  endfunction

  function automatic plk_hit_type plk_reg_lookup(input logic [ADDR_W-1:0] a);
    case (a)
      16'h3800: plk_reg_lookup = '{1'b1, 1'b0, 5'h00}; // summary_alarm
      16'h3801: plk_reg_lookup = '{1'b1, 1'b0, 5'h01}; // digital_output_state
      16'h3802: plk_reg_lookup = '{1'b1, 1'b0, 5'h02}; // digital_input_state
      16'h3814: plk_reg_lookup = '{1'b1, 1'b0, 5'h03}; // loop_measured_value
      16'h3815: plk_reg_lookup = '{1'b1, 1'b0, 5'h04}; // loop_target_value
      16'h3816: plk_reg_lookup = '{1'b1, 1'b0, 5'h05}; // output_value
      16'h3852: plk_reg_lookup = '{1'b1, 1'b0, 5'h06}; // sensor1_on_current
      16'h3853: plk_reg_lookup = '{1'b1, 1'b0, 5'h07}; // sensor2_on_current
      16'h3854: plk_reg_lookup = '{1'b1, 1'b0, 5'h08}; // heating_output_value
      16'h3855: plk_reg_lookup = '{1'b1, 1'b0, 5'h09}; // cooling_output_value
      16'h3900: plk_reg_lookup = '{1'b1, 1'b1, 5'h0a}; // local_target_group_select
      16'h3901: plk_reg_lookup = '{1'b1, 1'b1, 5'h0b}; // local_target_active
      16'h3902: plk_reg_lookup = '{1'b1, 1'b1, 5'h0c}; // manual_output_value
      16'h3903: plk_reg_lookup = '{1'b1, 1'b1, 5'h0d}; // run_standby_select
      16'h3904: plk_reg_lookup = '{1'b1, 1'b1, 5'h0e}; // auto_manual_select
      16'h3905: plk_reg_lookup = '{1'b1, 1'b1, 5'h0f}; // autotune_start_stop
      16'h3a00: plk_reg_lookup = '{1'b1, 1'b1, 5'h10}; // proportional_band_active
      16'h3a01: plk_reg_lookup = '{1'b1, 1'b1, 5'h11}; // integral_time_active
      16'h3a02: plk_reg_lookup = '{1'b1, 1'b1, 5'h12}; // derivative_time_active
      16'h3a03: plk_reg_lookup = '{1'b1, 1'b1, 5'h13}; // manual_reset_active
      16'h3a04: plk_reg_lookup = '{1'b1, 1'b1, 5'h14}; // output_low_limit_active
      16'h3a05: plk_reg_lookup = '{1'b1, 1'b1, 5'h15}; // output_high_limit_active
      16'h3a06: plk_reg_lookup = '{1'b1, 1'b1, 5'h16}; // cool_proportional_band_active
      16'h3a07: plk_reg_lookup = '{1'b1, 1'b1, 5'h17}; // cool_integral_time_active
      16'h3a08: plk_reg_lookup = '{1'b1, 1'b1, 5'h18}; // cool_derivative_time_active
      16'h3a0a: plk_reg_lookup = '{1'b1, 1'b1, 5'h19}; // cool_output_low_limit_active
      16'h3a0b: plk_reg_lookup = '{1'b1, 1'b1, 5'h1a}; // cool_output_high_limit_active
      default: plk_reg_lookup = '{1'b0, 1'b0, 5'h00};
    endcase
  endfunction
endpackage

//--- shared/plk_link_if.sv
`timescale 1ns/1ps
interface plk_link_if;
  logic req_valid;
  logic req_write;
  plk_pkg::plk_proto_type req_proto;
  logic [7:0] req_id;
  logic [plk_pkg::ADDR_W-1:0] req_addr;
  logic [plk_pkg::DATA_W-1:0] req_data;
  logic rsp_valid;
  logic rsp_error;
  logic [plk_pkg::DATA_W-1:0] rsp_data;
  modport ctrl_end(
    output req_valid, req_write, req_proto, req_id, req_addr, req_data,
    input rsp_valid, rsp_error, rsp_data
  );
  modport plc_end(
    input req_valid, req_write, req_proto, req_id, req_addr, req_data,
    output rsp_valid, rsp_error, rsp_data
  );
endinterface

//--- logic/plk_fifo.sv
`timescale 1ns/1ps
module plk_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
)(
  input wire logic clock,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  typedef struct packed {
    logic [PW-1:0] wr;
    logic [PW-1:0] rd;
    logic [PW:0] count;
  } plk_fifo_state_type;
  plk_fifo_state_type state_reg, state_next;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  assign in_ready = state_reg.count != (PW+1)'(DEPTH);
  assign out_valid = state_reg.count != '0;
  assign out_data = mem[state_reg.rd];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    state_next = state_reg;
    if (push) state_next.wr = state_reg.wr + 1'b1;
    if (pop) state_next.rd = state_reg.rd + 1'b1;
    state_next.count = state_reg.count + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge clock) begin
    if (reset) state_reg <= '0;
    else state_reg <= state_next;
  end

  always_ff @(posedge clock) begin
    if (push) mem[state_reg.wr] <= in_data;
  end
endmodule // plk_fifo

//--- logic/plk_plc_end.sv
`timescale 1ns/1ps
module plk_plc_end (
  input wire logic clock,
  input wire logic reset,
  plk_link_if.plc_end link,
  input wire logic [7:0] own_id,
  input wire plk_pkg::plk_proto_type own_proto,
  input wire logic usr_we,
  input wire logic [7:0] usr_addr,
  input wire logic [plk_pkg::DATA_W-1:0] usr_wdata,
  output logic [plk_pkg::DATA_W-1:0] usr_rdata,
  output logic id_invalid
);
  import plk_pkg::*;
  typedef struct packed {
    logic rsp_valid;
    logic rsp_error;
    logic [DATA_W-1:0] rsp_data;
    logic [DATA_W-1:0] usr_rdata;
    logic id_invalid;
  } plk_plc_state_type;
  plk_plc_state_type state_reg, state_next;
  logic [DATA_W-1:0] mem [PLC_MEM_WORDS];
  logic take;
  logic mem_we;

  // A request still standing in the answer cycle is the one just served
  assign take = link.req_valid && !state_reg.rsp_valid;
  // Only this single responder answers; a foreign id gets an error
  assign mem_we = take && link.req_write && !state_reg.id_invalid &&
                  link.req_id == own_id && link.req_proto == own_proto;

  always_comb begin
    state_next = state_reg;
    state_next.rsp_valid = take;
    state_next.usr_rdata = mem[usr_addr];
    state_next.id_invalid = own_id == ID_RESERVED_HI || own_id == ID_RESERVED_LO;
    if (take) begin
      // Id clash or wrong frame family is answered with an error
      state_next.rsp_error = state_reg.id_invalid || link.req_id != own_id ||
                             link.req_proto != own_proto;
      // Words are a flat block of consecutive locations
      state_next.rsp_data = mem[link.req_addr[7:0]];
    end
  end

  always_ff @(posedge clock) begin
    if (reset) state_reg <= '0;
    else state_reg <= state_next;
  end

  // A link write beats a user write in the same cycle
  always_ff @(posedge clock) begin
    if (mem_we) mem[link.req_addr[7:0]] <= link.req_data;
    else if (usr_we) mem[usr_addr] <= usr_wdata;
  end

  assign link.rsp_valid = state_reg.rsp_valid;
  assign link.rsp_error = state_reg.rsp_error;
  assign link.rsp_data = state_reg.rsp_data;
  assign usr_rdata = state_reg.usr_rdata;
  assign id_invalid = state_reg.id_invalid;
endmodule // plk_plc_end

//--- bench/plk_link_asserts.sv
`timescale 1ns/1ps
module plk_link_asserts (
  input wire logic clock,
  input wire logic reset,
  input wire logic req_valid,
  input wire plk_pkg::plk_proto_type req_proto,
  input wire logic [7:0] req_id,
  input wire logic [plk_pkg::ADDR_W-1:0] req_addr,
  input wire logic rsp_valid,
  input wire logic rsp_error,
  input wire logic id_invalid,
  input wire logic link_active,
  input wire logic host_comm_enable
);
  import plk_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  sequence s_taken; req_valid && !rsp_valid; endsequence
  sequence s_answer; rsp_valid ##1 !req_valid; endsequence
  AST_ANSWER: assert property (s_taken |=> s_answer)
    else $error("link answer not one cycle after request");
  AST_RSP_PULSE: assert property (rsp_valid |=> !rsp_valid)
    else $error("answer longer than one cycle");
  AST_REQ_HOLD: assert property (s_taken |=> $stable(req_addr) && $stable(req_id))
    else $error("request changed while waiting");
  AST_RSP_NEEDS_REQ: assert property (rsp_valid |-> req_valid)
    else $error("answer without request");
  AST_ID_RESERVED: assert property (rsp_valid && id_invalid |-> rsp_error)
    else $error("reserved id answered without error");
  AST_HOST_OFF: assert property (link_active |-> !host_comm_enable)
    else $error("host service on while link runs");
  AST_QUIET: assert property (!link_active |-> !req_valid)
    else $error("request before settings captured");
  AST_ONE_PROTO: assert property (link_active ##1 link_active |-> $stable(req_proto))
    else $error("protocol changed while running");
endmodule // plk_link_asserts

//--- bench/plc_link_data_transfer_tb_top.sv
`timescale 1ns/1ps
module plc_link_data_transfer_tb_top;
  import plk_pkg::*;
  logic clock = 1'b0, reset = 1'b1, trig = 1'b0, lock = 1'b0, lwe = 1'b0, lram = 1'b0;
  logic swe = 1'b0, mwe = 1'b0, uwe = 1'b0;
  logic [7:0] loop_tuning_terms = 8'h20, oid = 8'h20, stn = 8'h01, ua = 8'h00, str = 8'h00, snt = 8'h00;
  logic [1:0] usel = 2'h0;
  logic [5:0] lidx = 6'h00;
  logic [6:0] scnt = 7'h00;
  logic [15:0] lca = 16'h0000, lpa = 16'h0000, wa = 16'h0000, wd = 16'h0000;
  logic act, hce, cerr, lerr, wref, wv, wram, idinv, lw_ram;
  logic [15:0] waddr, wdata, rdata, lw_addr, lw_data;
  int n_fail = 0, checked = 0, nwr = 0, k;
  plk_link_if link ();
  initial forever #20 clock = ~clock;
  // Short periods keep the run brief; scan and repeat timing scale with them
  plk_ctrl_end #(.SCAN_CYCLES(20), .CYCLIC_CYCLES(50)) i_plk_ctrl_end (.clock(clock),
    .reset(reset), .link(link), .set_triggered(trig), .set_trig_init(trig),
    .set_proto(PROTO_RTU), .set_plc_id(loop_tuning_terms), .set_station(stn), .set_unit_sel(usel),
    .set_sheets(3'h1), .cfg_lock(lock), .line_we(lwe), .line_idx(lidx), .line_ctrl_addr(lca),
    .line_plc_addr(lpa), .line_ram(lram), .sheet_we(swe), .sheet_idx(2'h0), .sheet_first(6'h00),
    .sheet_count(scnt), .sheet_trig_addr({8'h00, str}), .sheet_notify_addr({8'h00, snt}),
    .mon_we(mwe), .mon_addr(wa), .mon_data(wd), .link_active(act), .host_comm_enable(hce),
    .cfg_error(cerr), .link_error(lerr), .write_refused(wref), .ctrl_wr_valid(wv),
    .ctrl_wr_addr(waddr), .ctrl_wr_data(wdata), .ctrl_wr_ram(wram));
  plk_plc_end i_plk_plc_end (.clock(clock), .reset(reset), .link(link), .own_id(oid),
    .own_proto(PROTO_RTU), .usr_we(uwe), .usr_addr(ua), .usr_wdata(wd), .usr_rdata(rdata),
    .id_invalid(idinv));
  plk_link_asserts i_plk_link_asserts (.clock(clock), .reset(reset),
    .req_valid(link.req_valid), .req_proto(link.req_proto), .req_id(link.req_id),
    .req_addr(link.req_addr), .rsp_valid(link.rsp_valid), .rsp_error(link.rsp_error),
    .id_invalid(idinv), .link_active(act), .host_comm_enable(hce));
  always @(posedge clock) begin
    if (wv === 1'b1) begin
      nwr <= nwr + 1;
      lw_addr <= waddr;
      lw_data <= wdata;
      lw_ram <= wram;
    end
  end
  task check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task report_and_stop;
    if (n_fail == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // One task serves both memories; the strobe decides which side takes the word
  task wr(input logic plc, input logic [15:0] a, input logic [15:0] d);
    @(posedge clock);
    uwe <= plc;
    mwe <= !plc;
    ua <= a[7:0];
    wa <= a;
    wd <= d;
    @(posedge clock);
    uwe <= 1'b0;
    mwe <= 1'b0;
  endtask
  task line(input logic [5:0] i, input logic [15:0] c, input logic [15:0] p, input logic r);
    @(posedge clock);
    lwe <= 1'b1;
    lidx <= i;
    lca <= c;
    lpa <= p;
    lram <= r;
    @(posedge clock);
    lwe <= 1'b0;
  endtask
  task sheet(input logic [6:0] n, input logic [7:0] t, input logic [7:0] f);
    @(posedge clock);
    swe <= 1'b1;
    scnt <= n;
    str <= t;
    snt <= f;
    @(posedge clock);
    swe <= 1'b0;
  endtask
  task power(input logic tr, input logic [7:0] id, input logic [7:0] st, input logic [1:0] us);
    @(posedge clock);
    reset <= 1'b1;
    trig <= tr;
    loop_tuning_terms <= id;
    stn <= st;
    usel <= us;
    repeat (4) @(posedge clock);
    reset <= 1'b0;
  endtask
  task go;
    @(posedge clock);
    lock <= 1'b1;
    @(posedge clock);
    lock <= 1'b0;
    #1;
  endtask
  // Read data lags the address by one cycle, so the stale word is skipped first
  task wait_mem(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    ua <= a;
    repeat (2) @(posedge clock);
    #1;
    for (k = 0; k < 3000 && rdata !== d; k++) begin
      @(posedge clock);
      #1;
    end
    check(rdata, d);
    if (k == 3000) report_and_stop;
  endtask
  initial begin
    power(1'b0, 8'h20, 8'h1f, 2'h3);
    wr(1'b0, 16'h3814, 16'h1234);
    wr(1'b0, 16'h3900, 16'habcd);
    wr(1'b1, 16'h0030, 16'h0000);
    line(6'h00, 16'h3814, 16'h0010, 1'b0);
    line(6'h01, 16'h3900, 16'h0011, 1'b0);
    sheet(7'h02, 8'h50, 8'h30);
    check(16'(hce), 16'h0001);
    go;
    check(16'(act), 16'h0001);
    check(16'(hce), 16'h0000);
    wait_mem(8'h30, 16'h0002);
    wait_mem(8'h10, 16'h1234);
    wait_mem(8'h11, 16'habcd);
    go;
    check(16'({act, cerr}), 16'h0002);
    power(1'b1, 8'h20, 8'h10, 2'h1);
    wr(1'b1, 16'h0040, 16'h5555);
    wr(1'b1, 16'h0041, 16'h6666);
    wr(1'b1, 16'h0050, 16'h0000);
    wr(1'b1, 16'h0051, 16'h0000);
    line(6'h00, 16'h3902, 16'h0040, 1'b1);
    line(6'h01, 16'h3800, 16'h0041, 1'b0);
    sheet(7'h02, 8'h50, 8'h51);
    go;
    repeat (60) @(posedge clock);
    #1 check(16'(nwr), 16'h0000);
    wr(1'b1, 16'h0050, 16'h0001);
    wait_mem(8'h51, 16'h0002);
    check(16'(nwr), 16'h0001);
    check(lw_addr, 16'h3902);
    check(lw_data, 16'h5555);
    check(16'(lw_ram), 16'h0001);
    check(16'(wref), 16'h0001);
    wait_mem(8'h50, 16'h0000);
    wr(1'b1, 16'h0051, 16'h0000);
    wr(1'b1, 16'h0040, 16'h7777);
    wr(1'b1, 16'h0050, 16'h0001);
    wait_mem(8'h51, 16'h0002);
    check(lw_data, 16'h7777);
    power(1'b0, 8'h20, 8'h09, 2'h0);
    go;
    check(16'({act, cerr}), 16'h0001);
    power(1'b0, 8'h21, 8'h01, 2'h0);
    oid <= 8'hff;
    go;
    for (k = 0; k < 200 && lerr !== 1'b1; k++) @(posedge clock);
    #1 check(16'({idinv, lerr}), 16'h0003);
    if (k == 200) report_and_stop;
    power(1'b0, 8'h20, 8'h01, 2'h0);
    oid <= 8'h20;
    // Twenty lines overflow the 16-word buffer, so the sheet runs in two chunks
    for (k = 0; k < 20; k++) begin
      line(6'(k), k == 16 ? 16'h3900 : 16'h3814, 16'(8'h60 + k), 1'b0);
    end
    sheet(7'h14, 8'h50, 8'h31);
    go;
    wait_mem(8'h31, 16'h0014);
    wait_mem(8'h70, 16'habcd);
    wait_mem(8'h73, 16'h1234);
    check(16'(nwr), 16'h0002);
    report_and_stop;
  end
endmodule // plc_link_data_transfer_tb_top
